// *** hw/drfa_pkg.sv ***
/*
 Package for the refresh arbiter: clock and refresh timing constants,
 sequencer step positions, mux modes and the identification value.
 Assumes a single 40 MHz clock drives every module that imports it.
*/
package drfa_pkg;
    // ========================================
    // Clocking
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned MOD_CLK_HZ = 12500000;
    localparam int unsigned REF_CLK_HZ = 97600;
    localparam int unsigned MOD_DIV = (CLK_HZ + MOD_CLK_HZ - 1) / MOD_CLK_HZ;
    localparam int unsigned REF_DIV_RATIO = MOD_CLK_HZ / REF_CLK_HZ;
    localparam int unsigned REF_PERIOD_MS = 2;
    localparam int unsigned REF_ROWS = 128;
    localparam logic [2:0] MOD_DIV_LAST = 3'(MOD_DIV - 1);
    localparam logic [7:0] REF_DIV_LAST = 8'(REF_DIV_RATIO - 1);
    localparam logic [2:0] MOD_DIV_ZERO = 3'h0;
    localparam logic [7:0] REF_DIV_ZERO = 8'h00;

    // ========================================
    // Address layout
    localparam int unsigned ROW_W = 7;
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned DATA_W = 16;
    localparam logic [ROW_W-1:0] ROW_ZERO = 7'h00;

    // ========================================
    // Sequencer shift register steps
    localparam int unsigned SEQ_W = 6;
    localparam int unsigned SEQ_RAS = 0;
    localparam int unsigned SEQ_MUX = 1;
    localparam int unsigned SEQ_CAS = 2;
    localparam int unsigned SEQ_RW = 3;
    localparam int unsigned SEQ_END = 5;
    localparam logic [SEQ_W-1:0] SEQ_CLEAR = 6'h00;

    // Card-type identification; the value is arbitrary
    localparam logic [DATA_W-1:0] CARD_ID = 16'h0a5c;

    typedef enum logic [1:0] {
        DRFA_MUX_ROW,
        DRFA_MUX_COL,
        DRFA_MUX_REF
    } drfa_mux_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic byte_acc;
        logic upper;
    } drfa_req_s;

    typedef struct packed {
        logic mux_mode_a;
        logic mux_mode_b;
        logic mux_mode_c;
    } drfa_mode_s;
endpackage : drfa_pkg

// *** hw/drfa_addr_mux.sv ***
/*
 Address multiplexer with embedded refresh row counter.
 Assumes the host address is already synchronised and held stable.
*/
module drfa_addr_mux
    import drfa_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ref_tick,
    input wire drfa_mode_s mode,
    input wire logic [ADDR_W-1:0] addr,
    output logic [ROW_W-1:0] mux_addr_n,
    output logic [ROW_W-1:0] ref_row
);
    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] row_d;
    logic [ROW_W-1:0] sel;

    // ========================================
    // Refresh row counter
    always_comb begin
        row_d = row_q;
        if (ref_tick) begin
            row_d = ROW_W'(row_q + 1'b1); // R2 R5
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            row_q <= ROW_ZERO;
        end else begin
            row_q <= row_d;
        end
    end

    // ========================================
    // Output select: a+c row, b+c column, any other mode refresh row
    always_comb begin
        if (mode.mux_mode_a && mode.mux_mode_c) begin
            sel = addr[ROW_W-1:0]; // R11 R13
        end else if (mode.mux_mode_b && mode.mux_mode_c) begin
            sel = addr[ADDR_W-1:ROW_W]; // R11 R13
        end else begin
            sel = row_q; // R6
        end
    end

    assign mux_addr_n = ~sel; // R13
    assign ref_row = row_q;
endmodule : drfa_addr_mux

// *** hw/drfa_top.sv ***
/*
 Refresh arbiter and sequencer for a 16k x 16 dynamic memory card on an
 asynchronous host memory bus. Host pins are synchronised to REF_CLK.
 Assumes the host keeps address, data and direction stable while waiting.
*/
// Summary of operation
// [R1] Refresh all 128 rows every 2 ms
// [R2] Seven-bit refresh row counter in mux
// [R3] Derive 12.5 MHz step, 97.6 kHz refresh tick; the dividers give 10 MHz and 78.125 kHz
// [R4] Power-on pulse initialises clock dividers
// [R5] Tick advances row, requests refresh after host
// [R6] Refresh drives counter row and row strobe
// [R7] Latch host request, assert memory-sync wait
// [R8] Refresh cycle completes before a pending host cycle
// [R9] Op flag drops, rises, latches host active
// [R10] Timing step enables write, clears pending
// [R11] Row bits 0-6, then column bits 7-13
// [R12] Shift ones time row, select, column strobe
// [R13] Seven inverted outputs, two mode pairs
// [R14] Column strobe needs active, step, bank one
// [R15] Byte write strobes from byte and upper
// [R16] Read drives buffer enable and full word
// [R17] Reads return the whole word
// [R18] Slot select places card identification code
// [R19] Upper byte only with byte access
// [R20] Power-on clears pending, active, op flag
module drfa_top
    import drfa_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic START_MEM_N,
    input wire logic SLOT_SEL_N,
    input wire logic HOST_WRITE_N,
    input wire logic HOST_DATA_STROBE_N,
    input wire logic BYTE_ACCESS_N,
    input wire logic UPPER_BYTE_SEL_N,
    input wire logic BANK_ONE_SEL_N,
    input wire logic IDENTIFY_N,
    input wire logic [ADDR_W-1:0] HOST_ADDR_N,
    input wire logic [DATA_W-1:0] HOST_DATA_N_I,
    output logic [DATA_W-1:0] HOST_DATA_N_O,
    output logic [DATA_W-1:0] HOST_DATA_N_OE,
    output logic MEM_WAIT_N,
    output logic READ_BUF_EN_N,
    output logic [ROW_W-1:0] MUX_ROW_ADDR,
    output logic ROW_STROBE_N,
    output logic COL_STROBE_N,
    output logic WRITE_LOW_BYTE_N,
    output logic WRITE_HIGH_BYTE_N,
    output logic [DATA_W-1:0] RAM_WDATA,
    input wire logic [DATA_W-1:0] RAM_RDATA
);
    // ========================================
    // Input synchronisers
    localparam int unsigned SYNC_W = 8 + ADDR_W;
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic start_s, slot_s, write_s, strobe_s, byte_s, upper_s, bank_s, ident_s;
    logic [ADDR_W-1:0] addr_s;

    assign pin_raw = {~START_MEM_N, ~SLOT_SEL_N, ~HOST_WRITE_N, ~HOST_DATA_STROBE_N,
                      ~BYTE_ACCESS_N, ~UPPER_BYTE_SEL_N, ~BANK_ONE_SEL_N, ~IDENTIFY_N,
                      ~HOST_ADDR_N};

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
        end
    end

    assign {start_s, slot_s, write_s, strobe_s, byte_s, upper_s, bank_s, ident_s} =
        sync_q[SYNC_W-1:ADDR_W];
    assign addr_s = sync_q[ADDR_W-1:0];

    // ========================================
    // Clock dividers: 10 MHz step enable, 78.125 kHz refresh tick
    logic [2:0] mdiv_q, mdiv_d;
    logic [7:0] rdiv_q, rdiv_d;
    logic step_en, ref_tick;

    always_comb begin
        mdiv_d = mdiv_q;
        rdiv_d = rdiv_q;
        step_en = (mdiv_q == MOD_DIV_LAST); // R3
        ref_tick = step_en && (rdiv_q == REF_DIV_LAST); // R3 R1
        if (step_en) begin
            mdiv_d = MOD_DIV_ZERO;
            rdiv_d = ref_tick ? REF_DIV_ZERO : 8'(rdiv_q + 1'b1);
        end else begin
            mdiv_d = 3'(mdiv_q + 1'b1);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            mdiv_q <= MOD_DIV_ZERO; // R4
            rdiv_q <= REF_DIV_ZERO; // R4
        end else begin
            mdiv_q <= mdiv_d;
            rdiv_q <= rdiv_d;
        end
    end

    // ========================================
    // Arbiter and sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REFRESH,
        ST_HOST
    } drfa_st_e;

    drfa_st_e st_q, st_d;
    logic pend_q, pend_d;
    logic ref_req_q, ref_req_d;
    logic memop_q, memop_d;
    logic act_q, act_d;
    logic [SEQ_W-1:0] seq_q, seq_d;
    drfa_req_s req_q, req_d;
    logic start_prev_q;
    logic start_rise;
    logic seq_done;

    assign start_rise = start_s && slot_s && !start_prev_q;
    assign seq_done = seq_q[SEQ_END];

    always_comb begin
        st_d = st_q;
        pend_d = pend_q;
        ref_req_d = ref_req_q;
        memop_d = memop_q;
        act_d = act_q;
        seq_d = seq_q;
        req_d = req_q;
        if (ref_tick) begin
            ref_req_d = 1'b1; // R5
        end
        if (start_rise && !pend_q && !act_q) begin
            pend_d = 1'b1; // R7
            req_d = '{addr: addr_s, write: write_s, byte_acc: byte_s, upper: upper_s};
        end
        if (step_en) begin
            unique case (st_q)
                ST_IDLE: begin
                    // Refresh waits for a host cycle under way; a pending host waits for refresh
                    if (ref_req_q) begin
                        st_d = ST_REFRESH; // R5 R8
                        memop_d = 1'b1;
                        ref_req_d = ref_tick;
                        seq_d = SEQ_CLEAR;
                    end else if (pend_q) begin
                        st_d = ST_HOST; // R9
                        memop_d = 1'b1;
                        act_d = 1'b1; // R9
                        seq_d = SEQ_CLEAR;
                    end
                end
                ST_REFRESH, ST_HOST: begin
                    seq_d = {seq_q[SEQ_W-2:0], 1'b1}; // R12
                    if (st_q == ST_HOST && seq_q[SEQ_RW]) begin
                        pend_d = 1'b0; // R10
                    end
                    if (seq_done) begin
                        st_d = ST_IDLE;
                        memop_d = 1'b0; // R9 R12
                        act_d = 1'b0;
                        seq_d = SEQ_CLEAR;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            st_q <= ST_IDLE; // R20
            pend_q <= 1'b0; // R20
            ref_req_q <= 1'b0;
            memop_q <= 1'b0; // R20
            act_q <= 1'b0; // R20
            seq_q <= SEQ_CLEAR;
            req_q <= '0;
            start_prev_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pend_q <= pend_d;
            ref_req_q <= ref_req_d;
            memop_q <= memop_d;
            act_q <= act_d;
            seq_q <= seq_d;
            req_q <= req_d;
            start_prev_q <= start_s && slot_s;
        end
    end

    // ========================================
    // Address mux and refresh counter
    drfa_mode_s mode;
    logic [ROW_W-1:0] mux_n;

    always_comb begin
        mode = '{mux_mode_a: 1'b0, mux_mode_b: 1'b0, mux_mode_c: 1'b0};
        if (st_q == ST_HOST) begin
            mode.mux_mode_c = 1'b1;
            mode.mux_mode_a = !seq_q[SEQ_MUX]; // R11
            mode.mux_mode_b = seq_q[SEQ_MUX]; // R11
        end
    end

    drfa_addr_mux u_mux (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .ref_tick(ref_tick),
        .mode(mode),
        .addr(req_q.addr),
        .mux_addr_n(mux_n),
        .ref_row()
    );

    // ========================================
    // Strobes, byte writes, read buffer, identification
    logic ras_q, cas_q, wrl_q, wru_q, buf_q, wait_q;
    logic [ROW_W-1:0] row_o_q;
    logic [DATA_W-1:0] dout_q, doe_q, wdata_q;
    // Both data buses change off our clock: two flops before any use
    logic [DATA_W-1:0] wdata_m_q, wdata_s_q, rdata_m_q, rdata_s_q;
    logic ras_d, cas_d, wrl_d, wru_d, buf_d, rw_en;
    logic [DATA_W-1:0] dout_d, doe_d;

    always_comb begin
        rw_en = act_q && seq_q[SEQ_RW]; // R10
        ras_d = memop_q && seq_q[SEQ_RAS]; // R6 R12
        cas_d = act_q && seq_q[SEQ_CAS] && bank_s; // R14
        wrl_d = 1'b0;
        wru_d = 1'b0;
        if (rw_en && req_q.write) begin
            wru_d = !req_q.byte_acc || req_q.upper; // R15 R19
            wrl_d = !req_q.byte_acc || !req_q.upper; // R15
        end
        buf_d = !write_s && strobe_s && act_q && !req_q.write; // R16 R17
        dout_d = '0;
        doe_d = '0;
        if (buf_d) begin
            dout_d = ~rdata_s_q; // R16 R17
            doe_d = '1;
        end else if (ident_s && slot_s) begin
            dout_d = ~CARD_ID; // R18
            doe_d = '1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            ras_q <= 1'b0;
            cas_q <= 1'b0;
            wrl_q <= 1'b0;
            wru_q <= 1'b0;
            buf_q <= 1'b0;
            wait_q <= 1'b0;
            row_o_q <= ROW_ZERO;
            dout_q <= '0;
            doe_q <= '0;
            wdata_q <= '0;
            wdata_m_q <= '0;
            wdata_s_q <= '0;
            rdata_m_q <= '0;
            rdata_s_q <= '0;
        end else begin
            ras_q <= ras_d;
            cas_q <= cas_d;
            wrl_q <= wrl_d;
            wru_q <= wru_d;
            buf_q <= buf_d;
            wait_q <= pend_d; // R7 R10
            row_o_q <= ~mux_n;
            dout_q <= dout_d;
            doe_q <= doe_d;
            wdata_m_q <= HOST_DATA_N_I;
            wdata_s_q <= wdata_m_q;
            wdata_q <= ~wdata_s_q;
            rdata_m_q <= RAM_RDATA;
            rdata_s_q <= rdata_m_q;
        end
    end

    assign MEM_WAIT_N = !wait_q;
    assign ROW_STROBE_N = !ras_q;
    assign COL_STROBE_N = !cas_q;
    assign WRITE_LOW_BYTE_N = !wrl_q;
    assign WRITE_HIGH_BYTE_N = !wru_q;
    assign READ_BUF_EN_N = !buf_q;
    assign MUX_ROW_ADDR = row_o_q;
    assign HOST_DATA_N_O = dout_q;
    // Enable is low while driving
    assign HOST_DATA_N_OE = ~doe_q;
    assign RAM_WDATA = wdata_q;
endmodule : drfa_top

// *** tb/drfa_top_asserts.sv ***
/*
 Port checker for drfa_top, bound at the foot of this file.
 Assumes the host holds direction and bank select steady through each cycle.
*/
module drfa_top_chk
    import drfa_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic HOST_WRITE_N,
    input wire logic BANK_ONE_SEL_N,
    input wire logic [DATA_W-1:0] HOST_DATA_N_OE,
    input wire logic MEM_WAIT_N,
    input wire logic READ_BUF_EN_N,
    input wire logic [ROW_W-1:0] MUX_ROW_ADDR,
    input wire logic ROW_STROBE_N,
    input wire logic COL_STROBE_N,
    input wire logic WRITE_LOW_BYTE_N,
    input wire logic WRITE_HIGH_BYTE_N
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================
    // Cycles since the last row strobe, saturating
    logic [9:0] gap_q;
    logic [9:0] gap_d;
    always_comb begin
        gap_d = gap_q;
        if (!ROW_STROBE_N) begin
            gap_d = 10'h000;
        end else if (gap_q != 10'h3ff) begin
            gap_d = gap_q + 10'h001;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            gap_q <= 10'h000;
        end else begin
            gap_q <= gap_d;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    // 625 cycles is 2 ms shared among 128 rows
    chk_refresh_gap: assert property (gap_q <= 10'h271)
        else $error("row strobe absent too long");
    chk_reset_idle: assert property ($rose(RST_B) |-> MEM_WAIT_N && ROW_STROBE_N
        && COL_STROBE_N && (HOST_DATA_N_OE == 16'hffff)) else $error("not idle after reset");
    chk_cas_in_ras: assert property (!COL_STROBE_N |-> !ROW_STROBE_N)
        else $error("column strobe outside row strobe");
    chk_cas_bank: assert property (!COL_STROBE_N |-> !BANK_ONE_SEL_N)
        else $error("column strobe without bank select");
    chk_col_settled: assert property ($fell(COL_STROBE_N) |-> $stable(MUX_ROW_ADDR))
        else $error("address moved at column strobe");
    chk_write_dir: assert property ((!WRITE_LOW_BYTE_N || !WRITE_HIGH_BYTE_N)
        |-> !HOST_WRITE_N && !ROW_STROBE_N) else $error("write strobe off a write cycle");
    chk_buf_read: assert property ($fell(READ_BUF_EN_N) |-> HOST_WRITE_N
        ##[0:2] (HOST_DATA_N_OE == 16'h0000)) else $error("read buffer without full drive");
    chk_wait_free: assert property ($fell(MEM_WAIT_N) |-> ##[1:120] $rose(MEM_WAIT_N))
        else $error("memory wait never released");
    chk_ras_whole: assert property ($fell(ROW_STROBE_N) |-> !ROW_STROBE_N [*4])
        else $error("row strobe cut short");
endmodule : drfa_top_chk

bind drfa_top drfa_top_chk chk_u (
    .REF_CLK(REF_CLK),
    .RST_B(RST_B),
    .HOST_WRITE_N(HOST_WRITE_N),
    .BANK_ONE_SEL_N(BANK_ONE_SEL_N),
    .HOST_DATA_N_OE(HOST_DATA_N_OE),
    .MEM_WAIT_N(MEM_WAIT_N),
    .READ_BUF_EN_N(READ_BUF_EN_N),
    .MUX_ROW_ADDR(MUX_ROW_ADDR),
    .ROW_STROBE_N(ROW_STROBE_N),
    .COL_STROBE_N(COL_STROBE_N),
    .WRITE_LOW_BYTE_N(WRITE_LOW_BYTE_N),
    .WRITE_HIGH_BYTE_N(WRITE_HIGH_BYTE_N)
);

// *** tb/drfa_host_model.sv ***
/*
 Host processor model on the memory bus side of drfa_top.
 Assumes the bench calls its tasks from one process only.
*/
module drfa_host_model
    import drfa_pkg::*;
(
    input wire logic clk,
    input wire logic mem_wait_n,
    input wire logic [DATA_W-1:0] data_o_n,
    output logic start_n,
    output logic slot_n,
    output logic ident_n,
    output logic write_n,
    output logic strobe_n,
    output logic byte_n,
    output logic upper_n,
    output logic [ADDR_W-1:0] addr_n,
    output logic [DATA_W-1:0] data_n,
    output logic timed_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {start_n, slot_n, ident_n, write_n, strobe_n, byte_n, upper_n} = 7'h7f;
        addr_n = 14'h0000;
        data_n = 16'h0000;
        timed_out = 1'b0;
    end

    // ========================================
    // One memory cycle, held until well after the wait ends
    task automatic access(input logic w, input logic b, input logic u,
                          input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        int post;
        logic seen;
        seen = 1'b0;
        post = 0;
        @(posedge clk) #2;
        addr_n = ~a;
        data_n = ~d;
        write_n = ~w;
        byte_n = ~b;
        upper_n = ~(u & b);
        strobe_n = 1'b0;
        start_n = 1'b0;
        slot_n = 1'b0;
        for (n = 0; n < 300 && post < 16; n++) begin
            @(posedge clk) #2;
            seen |= !mem_wait_n;
            if (seen && mem_wait_n) post++;
        end
        timed_out = (post < 16);
        {start_n, slot_n, strobe_n} = 3'h7;
        // Released lines flip rather than keep their last value
        addr_n = a;
        data_n = d;
    endtask : access

    task automatic identify(output logic [DATA_W-1:0] v);
        @(posedge clk) #2;
        slot_n = 1'b0;
        ident_n = 1'b0;
        repeat (6) @(posedge clk);
        #2 v = data_o_n;
        slot_n = 1'b1;
        ident_n = 1'b1;
    endtask : identify
endmodule : drfa_host_model

// *** tb/tb_drfa_top.sv ***
/*
 Self-checking bench for drfa_top with a host model and a bench-driven RAM read word.
 Assumes the checker is bound to the design separately.
*/
module tb_drfa_top
    import drfa_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic REF_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic BANK_ONE_SEL_N = 1'b0;
    logic [DATA_W-1:0] RAM_RDATA = 16'h0000;
    wire logic st_n, sl_n, id_n, wr_n, sb_n, by_n, up_n, tmo;
    wire logic [ADDR_W-1:0] ad_n;
    wire logic [DATA_W-1:0] di_n, do_n, oe_n, ram_wd;
    wire logic mw_n, buf_n, ras_n, cas_n, wl_n, wh_n;
    wire logic [ROW_W-1:0] mux;
    int failures = 0;
    int samples_checked = 0;
    logic prev_ras, prev_cas, saw_lo, saw_hi, saw_buf, saw_cas;
    logic [ROW_W-1:0] last_row, row_seen, col_seen;
    logic [DATA_W-1:0] rd_seen, wd_seen, oe_seen;
    logic [ROW_W-1:0] ref_q[$];

    always #12.5 REF_CLK = ~REF_CLK;

    drfa_top dut_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .START_MEM_N(st_n), .SLOT_SEL_N(sl_n),
        .HOST_WRITE_N(wr_n), .HOST_DATA_STROBE_N(sb_n), .BYTE_ACCESS_N(by_n),
        .UPPER_BYTE_SEL_N(up_n), .BANK_ONE_SEL_N(BANK_ONE_SEL_N), .IDENTIFY_N(id_n),
        .HOST_ADDR_N(ad_n), .HOST_DATA_N_I(di_n), .HOST_DATA_N_O(do_n), .HOST_DATA_N_OE(oe_n),
        .MEM_WAIT_N(mw_n), .READ_BUF_EN_N(buf_n), .MUX_ROW_ADDR(mux), .ROW_STROBE_N(ras_n),
        .COL_STROBE_N(cas_n), .WRITE_LOW_BYTE_N(wl_n), .WRITE_HIGH_BYTE_N(wh_n),
        .RAM_WDATA(ram_wd), .RAM_RDATA(RAM_RDATA));

    drfa_host_model host_u (.clk(REF_CLK), .mem_wait_n(mw_n), .data_o_n(do_n), .start_n(st_n),
        .slot_n(sl_n), .ident_n(id_n), .write_n(wr_n), .strobe_n(sb_n), .byte_n(by_n),
        .upper_n(up_n), .addr_n(ad_n), .data_n(di_n), .timed_out(tmo));

    // ========================================
    // Monitor: values sampled here are those settled before the edge
    always @(posedge REF_CLK) begin
        prev_ras <= ras_n;
        prev_cas <= cas_n;
        if (prev_ras && !ras_n) begin
            last_row <= mux;
            if (st_n) ref_q.push_back(mux);
        end
        if (prev_cas && !cas_n) begin
            saw_cas <= 1'b1;
            row_seen <= last_row;
            col_seen <= mux;
        end
        if (!wl_n) saw_lo <= 1'b1;
        if (!wh_n) saw_hi <= 1'b1;
        if (!wl_n || !wh_n) wd_seen <= ram_wd;
        if (!buf_n) begin
            saw_buf <= 1'b1;
            rd_seen <= ~do_n;
            oe_seen <= oe_n;
        end
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic run(input logic w, input logic b, input logic u,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        {saw_lo, saw_hi, saw_buf, saw_cas} = 4'h0;
        host_u.access(w, b, u, a, d);
        if (tmo) begin
            failures++;
            wrap_up();
        end
        check(mw_n, 1'b1);
        if (w) check({saw_buf, saw_lo | saw_hi}, 2'h1);
    endtask : run

    task automatic s_reset();
        check({mw_n, ras_n, cas_n, wl_n, wh_n, buf_n}, 6'h3f);
        check(oe_n, 16'hffff);
        check(mux, 7'h00);
    endtask : s_reset

    task automatic s_writes();
        run(1'b1, 1'b0, 1'b0, 14'h1555, 16'hc3a5);
        check({saw_hi, saw_lo}, 2'h3);
        check(wd_seen, 16'hc3a5);
        check({row_seen, col_seen}, {7'h55, 7'h2a});
        for (int u = 0; u < 2; u++) begin
            run(1'b1, 1'b1, u[0], u[0] ? 14'h3fff : 14'h0000, 16'h0ff0);
            check({saw_hi, saw_lo}, {u[0], !u[0]});
        end
    endtask : s_writes

    task automatic s_reads();
        for (int b = 0; b < 2; b++) begin
            RAM_RDATA = b[0] ? 16'h5aa5 : 16'h8001;
            run(1'b0, b[0], b[0], 14'h3fff, 16'h0000);
            check({saw_buf, saw_lo, saw_hi}, 3'h4);
            check(rd_seen, RAM_RDATA);
            check(oe_seen, 16'h0000);
            check({row_seen, col_seen}, 14'h3fff);
        end
    endtask : s_reads

    task automatic s_bank_off();
        BANK_ONE_SEL_N = 1'b1;
        run(1'b1, 1'b0, 1'b0, 14'h0001, 16'h1234);
        check(saw_cas, 1'b0);
        @(posedge REF_CLK) #2 BANK_ONE_SEL_N = 1'b0;
    endtask : s_bank_off

    task automatic s_refresh();
        ref_q.delete();
        repeat (2000) @(posedge REF_CLK);
        check(ref_q.size() >= 3, 1'b1);
        for (int i = 1; i < ref_q.size(); i++) begin
            check(ref_q[i], ROW_W'(ref_q[i-1] + 7'h01));
        end
    endtask : s_refresh

    task automatic s_collide();
        int n;
        for (n = 0; n < 800 && ras_n; n++) @(posedge REF_CLK) #2;
        if (n == 800) begin
            failures++;
            wrap_up();
        end
        run(1'b1, 1'b0, 1'b0, 14'h2a81, 16'h7e7e);
        check({row_seen, col_seen}, {7'h01, 7'h55});
        run(1'b0, 1'b0, 1'b0, 14'h0180, 16'h0000);
        check({saw_buf, row_seen, col_seen}, {1'b1, 7'h00, 7'h03});
    endtask : s_collide

    task automatic s_ident();
        logic [DATA_W-1:0] v;
        host_u.identify(v);
        check(v, ~CARD_ID);
        check(oe_n, 16'h0000);
    endtask : s_ident

    initial begin
        repeat (16) @(posedge REF_CLK);
        #2 RST_B = 1'b1;
        s_reset();
        s_writes();
        s_reads();
        s_bank_off();
        s_refresh();
        s_collide();
        s_ident();
        wrap_up();
    end
endmodule : tb_drfa_top
